// >>> common/lmd_pkg.sv
// lmd_pkg: constants and types for the panel multiplex drive selector
package lmd_pkg;

   // ---------------------------------------------------------------
   // panel geometry
   // ---------------------------------------------------------------
   localparam int NUM_COLS      = 160;
   localparam int NUM_ROWS      = 4;
   localparam int COL_W         = 8;
   localparam int LVL_W         = 2;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int SYS_CLK_HZ    = 20_000_000;
   localparam int FRAME_CLK_HZ  = 1800;
   localparam int FRAME_CLK_DIV = SYS_CLK_HZ / FRAME_CLK_HZ;
   localparam int FRAME_TICKS   = 24;
   localparam logic [4:0] TICK_LAST  = 5'h17;
   localparam logic [4:0] LEN_STATIC = 5'h18;
   localparam logic [4:0] LEN_MUX2   = 5'h0C;
   localparam logic [4:0] LEN_MUX3   = 5'h08;
   localparam logic [4:0] LEN_MUX4   = 5'h06;

   // ---------------------------------------------------------------
   // bias: fraction 1/(1+a) of panel supply
   // ---------------------------------------------------------------
   localparam int BIAS_A_HALF   = 1;
   localparam int BIAS_A_THIRD  = 2;

   // ---------------------------------------------------------------
   // drive level codes, 0 = ground, 3 = panel_supply_level
   // in half bias both middle codes stand for one half of supply
   // ---------------------------------------------------------------
   localparam logic [1:0] LVL_GND    = 2'h0;
   localparam logic [1:0] LVL_LOW    = 2'h1;
   localparam logic [1:0] LVL_HIGH   = 2'h2;
   localparam logic [1:0] LVL_SUPPLY = 2'h3;

   // ---------------------------------------------------------------
   // drive modes and reset configuration
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      LMD_STATIC = 2'b00,
      LMD_MUX2   = 2'b01,
      LMD_MUX3   = 2'b10,
      LMD_MUX4   = 2'b11
   } lmd_mode_t;

   localparam lmd_mode_t RST_MODE    = LMD_MUX4;
   localparam logic      RST_HALF    = 1'b0;
   localparam logic      RST_ENABLE  = 1'b0;

endpackage : lmd_pkg

// >>> design/lmd_frame_gen.sv
// lmd_frame_gen: frame clock divider, phase sequencer and polarity
`timescale 1ns/1ps
`default_nettype none
module lmd_frame_gen #(
   parameter int FCLK_DIV = lmd_pkg::FRAME_CLK_DIV
) (
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire lmd_pkg::lmd_mode_t mode_i,
   output logic [1:0]             phase_o,
   output logic                   inv_o,
   output logic                   frame_start_o
);
   import lmd_pkg::*;

   logic [15:0] pre_q;
   logic [4:0]  tick_q;
   logic [4:0]  sub_q;
   logic [4:0]  len;
   logic        ftick;

   // ---------------------------------------------------------------
   // phase length: 24 ticks shared by the active backplanes
   // ---------------------------------------------------------------
   always_comb
   begin
      case (mode_i)
         LMD_STATIC: len = LEN_STATIC;
         LMD_MUX2:   len = LEN_MUX2;
         LMD_MUX3:   len = LEN_MUX3;
         LMD_MUX4:   len = LEN_MUX4;
         default:    len = LEN_MUX4;
      endcase
   end

   assign ftick = (pre_q == 16'(FCLK_DIV - 1));

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pre_q <= 16'h0000;
      else if (ftick)
         pre_q <= 16'h0000;
      else
         pre_q <= pre_q + 16'h0001;
   end

   // frame = 24 frame clock ticks
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         tick_q        <= 5'h00;
         sub_q         <= 5'h00;
         phase_o       <= 2'h0;
         inv_o         <= 1'b0;
         frame_start_o <= 1'b0;
      end
      else
      begin
         frame_start_o <= 1'b0;
         if (ftick)
         begin
            if (tick_q == TICK_LAST)
            begin
               tick_q        <= 5'h00;
               sub_q         <= 5'h00;
               phase_o       <= 2'h0;
               inv_o         <= ~inv_o;
               frame_start_o <= 1'b1;
            end
            else
            begin
               tick_q <= tick_q + 5'h01;
               // rows in order from 0 to the mode's last row (0..3 in 1:4) within a frame
               if (sub_q >= len - 5'h01)
               begin
                  sub_q   <= 5'h00;
                  phase_o <= phase_o + 2'h1;
               end
               else
                  sub_q <= sub_q + 5'h01;
            end
         end
      end
   end

endmodule // lmd_frame_gen
`default_nettype wire

// >>> design/lmd_top.sv
// lmd_top: display memory and backplane/segment level selection
`timescale 1ns/1ps
`default_nettype none
module lmd_top #(
   parameter int FCLK_DIV = lmd_pkg::FRAME_CLK_DIV
) (
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   cfg_load_i,
   input  wire lmd_pkg::lmd_mode_t     cfg_mode_i,
   input  wire logic                   cfg_half_bias_i,
   input  wire logic                   cfg_enable_i,
   input  wire logic                   wr_en_i,
   input  wire logic [lmd_pkg::COL_W-1:0] wr_col_i,
   input  wire logic [3:0]             wr_data_i,
   output logic [7:0]                  backplane_top_o,
   output logic [7:0]                  backplane_bottom_o,
   output logic [319:0]                segment_outputs_o
);
   import lmd_pkg::*;

   // ---------------------------------------------------------------
   // configuration
   // ---------------------------------------------------------------
   lmd_mode_t  mode_q;
   logic       half_q;
   logic       enable_q;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         mode_q   <= RST_MODE;
         half_q   <= RST_HALF;
         enable_q <= RST_ENABLE;
      end
      else if (cfg_load_i)
      begin
         mode_q   <= cfg_mode_i;
         half_q   <= cfg_half_bias_i;
         enable_q <= cfg_enable_i;
      end
   end

   // ---------------------------------------------------------------
   // frame timing
   // ---------------------------------------------------------------
   logic [1:0] phase;
   logic       inv;
   logic       frame_start;

   lmd_frame_gen #(
      .FCLK_DIV (FCLK_DIV)
   ) u_frame (
      .clk_i         (clk_i),
      .rst_n_i       (rst_n_i),
      .mode_i        (mode_q),
      .phase_o       (phase),
      .inv_o         (inv),
      .frame_start_o (frame_start)
   );

   // ---------------------------------------------------------------
   // display memory and display register
   // ---------------------------------------------------------------
   logic [3:0] ram_q  [NUM_COLS];
   logic [3:0] disp_q [NUM_COLS];

   // columns past 159 are ignored
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int c = 0; c < NUM_COLS; c++)
            ram_q[c] <= 4'h0;
      end
      else if (wr_en_i && (int'(wr_col_i) < NUM_COLS))
         ram_q[wr_col_i] <= wr_data_i;
   end

   // snapshot one clock after frame start, so the first output clock of a frame still shows old row 0 data
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         for (int c = 0; c < NUM_COLS; c++)
            disp_q[c] <= 4'h0;
      end
      else if (frame_start)
      begin
         for (int c = 0; c < NUM_COLS; c++)
            disp_q[c] <= ram_q[c];
      end
   end

   // ---------------------------------------------------------------
   // level selection
   // ---------------------------------------------------------------
   // logical backplane seen on physical output k
   function automatic logic [1:0] bp_map(lmd_mode_t m, logic [1:0] k);
      case (m)
         LMD_STATIC: bp_map = 2'h0;
         LMD_MUX2:   bp_map = {1'b0, k[0]};
         LMD_MUX3:   bp_map = (k == 2'h3) ? 2'h1 : k;
         LMD_MUX4:   bp_map = k;
         default:    bp_map = k;
      endcase
   endfunction

   // active backplane sits at a rail, others at a bias point
   function automatic logic [1:0] bp_level(logic act, logic iv,
                                           logic st, logic hb);
      if (act || st)
         bp_level = iv ? LVL_GND : LVL_SUPPLY;
      else if (hb)
         bp_level = LVL_LOW;
      else
         bp_level = iv ? LVL_HIGH : LVL_LOW;
   endfunction

   // a phase left over from a wider mode falls back to row 0
   function automatic logic [1:0] last_phase(lmd_mode_t m);
      case (m)
         LMD_STATIC: last_phase = 2'h0;
         LMD_MUX2:   last_phase = 2'h1;
         LMD_MUX3:   last_phase = 2'h2;
         LMD_MUX4:   last_phase = 2'h3;
         default:    last_phase = 2'h3;
      endcase
   endfunction

   // half bias folds both middle points onto LVL_LOW
   function automatic logic [1:0] seg_level(logic on, logic iv,
                                            logic st, logic hb);
      if (on)
         seg_level = iv ? LVL_SUPPLY : LVL_GND;
      else if (st)
         seg_level = iv ? LVL_GND : LVL_SUPPLY;
      else if (hb)
         seg_level = LVL_LOW;
      else
         seg_level = iv ? LVL_LOW : LVL_HIGH;
   endfunction

   logic       st_mode;
   logic       hb_eff;
   logic [1:0] ph;

   // mode changes mid-frame must never leave no backplane active
   assign ph      = (phase > last_phase(mode_q)) ? 2'h0 : phase;
   assign st_mode = (mode_q == LMD_STATIC);
   assign hb_eff  = half_q && !st_mode;

   // ---------------------------------------------------------------
   // output registers
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !enable_q)
      begin
         backplane_top_o    <= {4{LVL_SUPPLY}};
         backplane_bottom_o <= {4{LVL_SUPPLY}};
      end
      else
      begin
         for (int k = 0; k < NUM_ROWS; k++)
         begin
            // both pin sets get the same value
            backplane_top_o[2*k +: 2] <=
               bp_level(bp_map(mode_q, 2'(k)) == ph, inv, st_mode, hb_eff);
            backplane_bottom_o[2*k +: 2] <=
               bp_level(bp_map(mode_q, 2'(k)) == ph, inv, st_mode, hb_eff);
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || !enable_q)
         segment_outputs_o <= {NUM_COLS{LVL_SUPPLY}};
      else
      begin
         for (int c = 0; c < NUM_COLS; c++)
            // row = phase, 1 means on
            segment_outputs_o[2*c +: 2] <=
               seg_level(disp_q[c][ph], inv, st_mode, hb_eff);
      end
   end

endmodule // lmd_top
`default_nettype wire

// >>> verification/lmd_top_sva.sv
// port checker for the panel multiplex drive selector
`timescale 1ns/1ps
`default_nettype none
module lmd_top_sva #(
   parameter int FCLK_DIV = 2
) (
   input wire logic               clk_i,
   input wire logic               rst_n_i,
   input wire logic               cfg_load_i,
   input wire lmd_pkg::lmd_mode_t cfg_mode_i,
   input wire logic               cfg_half_bias_i,
   input wire logic               cfg_enable_i,
   input wire logic [7:0]         backplane_top_o,
   input wire logic [7:0]         backplane_bottom_o,
   input wire logic [319:0]       segment_outputs_o
);
   import lmd_pkg::*;
   // ---------------------------------------------------------------
   // config seen by the output stage, two edges behind the load
   // ---------------------------------------------------------------
   logic [3:0]      c_q;
   logic [3:0]      c_qq;
   wire logic [1:0] m  = c_qq[3:2];
   wire logic       h  = c_qq[1];
   wire logic       e  = c_qq[0];
   wire logic [7:0] bp = backplane_top_o;
   wire logic [1:0] s0 = segment_outputs_o[1:0];
   function automatic logic [2:0] act(input logic [1:0] v);
      return {2'h0, v == 2'h0 || v == 2'h3};
   endfunction
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         c_q  <= {RST_MODE, RST_HALF, RST_ENABLE};
         c_qq <= {RST_MODE, RST_HALF, RST_ENABLE};
      end
      else
      begin
         if (cfg_load_i)
            c_q <= {cfg_mode_i, cfg_half_bias_i, cfg_enable_i};
         c_qq <= c_q;
      end
   end
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_sib_equal: assert property (
      backplane_bottom_o == backplane_top_o)
      else $error("backplane sets differ");
   a_rst_supply: assert property (
      $rose(rst_n_i) |-> bp == 8'hFF && &segment_outputs_o)
      else $error("outputs not at supply after reset");
   a_dis_supply: assert property (
      !e |-> bp == 8'hFF && &segment_outputs_o)
      else $error("outputs not at supply while disabled");
   a_mux3_copy: assert property (
      m == LMD_MUX3 |-> bp[7:6] == bp[3:2])
      else $error("backplane 3 differs from 1");
   a_mux2_copy: assert property (
      m == LMD_MUX2 |-> bp[5:4] == bp[1:0] && bp[7:6] == bp[3:2])
      else $error("paired backplanes differ");
   a_static_equal: assert property (
      m == LMD_STATIC |-> bp == {4{bp[1:0]}})
      else $error("static backplanes differ");
   a_static_levels: assert property (
      m == LMD_STATIC |-> act(bp[1:0]) == 3'h1 && act(s0) == 3'h1)
      else $error("static drive uses a middle level");
   a_mux4_one: assert property (
      m == LMD_MUX4 && e |-> act(bp[1:0]) + act(bp[3:2])
         + act(bp[5:4]) + act(bp[7:6]) == 3'h1)
      else $error("not one active backplane in 1:4");
   a_mux2_one: assert property (
      m == LMD_MUX2 && e |-> act(bp[1:0]) + act(bp[3:2]) == 3'h1)
      else $error("not one active backplane in 1:2");
   a_mux3_one: assert property (
      m == LMD_MUX3 && e |->
         act(bp[1:0]) + act(bp[3:2]) + act(bp[5:4]) == 3'h1)
      else $error("not one active backplane in 1:3");
   a_half_mid: assert property (
      h && e && m != LMD_STATIC |-> bp[1:0] != 2'h2 && s0 != 2'h2)
      else $error("half bias uses the upper middle code");
endmodule // lmd_top_sva
bind lmd_top lmd_top_sva #(.FCLK_DIV(FCLK_DIV)) u_sva (
   .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_load_i(cfg_load_i),
   .cfg_mode_i(cfg_mode_i), .cfg_half_bias_i(cfg_half_bias_i),
   .cfg_enable_i(cfg_enable_i), .backplane_top_o(backplane_top_o),
   .backplane_bottom_o(backplane_bottom_o),
   .segment_outputs_o(segment_outputs_o)
);
`default_nettype wire

// >>> verification/lmd_panel_model.sv
// panel model: element state for one column and dc balance of its row 0 element
`timescale 1ns/1ps
`default_nettype none
module lmd_panel_model (
   input  wire logic       clk_i,
   input  wire logic       clr_i,
   input  wire logic       half_i,
   input  wire logic [7:0] bp_i,
   input  wire logic [1:0] seg_i,
   output logic [3:0]      on_o,
   output int              dc_o
);
   // half bias folds both middle codes onto half supply, in half units
   function automatic int volt(input logic [1:0] c);
      if (half_i && (c == 2'h1 || c == 2'h2))
         return 3;
      return 2 * int'(c);
   endfunction
   always_ff @(posedge clk_i)
   begin
      if (clr_i)
      begin
         on_o <= 4'h0;
         dc_o <= 0;
      end
      else
      begin
         // only a full-swing phase lights an element
         for (int r = 0; r < 4; r++)
            if (volt(bp_i[2*r+:2]) - volt(seg_i) inside {6, -6})
               on_o[r] <= 1'b1;
         dc_o <= dc_o + volt(bp_i[1:0]) - volt(seg_i);
      end
   end
endmodule // lmd_panel_model
`default_nettype wire

// >>> verification/lmd_top_bench.sv
// self-checking bench for the panel multiplex drive selector
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
   $display("Error %0t: got %h want %h", $time, a, b); end end
module lmd_top_bench;
   import lmd_pkg::*;
   localparam int DIV = 2;
   localparam int FR  = 24 * DIV;
   typedef struct packed {
      lmd_mode_t  m;
      logic       h;
      logic [7:0] c;
      logic [3:0] d;
      logic [3:0] e;
   } lmd_row_t;
   // expected rows follow the backplane copies of each mode
   localparam lmd_row_t ROWS [8] = '{
      '{LMD_STATIC, 1'b0, 8'h03, 4'h1, 4'hF},
      '{LMD_STATIC, 1'b1, 8'h03, 4'hE, 4'h0},
      '{LMD_MUX2, 1'b1, 8'h00, 4'h2, 4'hA},
      '{LMD_MUX2, 1'b0, 8'h9F, 4'h1, 4'h5},
      '{LMD_MUX3, 1'b0, 8'h07, 4'h4, 4'h4},
      '{LMD_MUX3, 1'b1, 8'h07, 4'hA, 4'hA},
      '{LMD_MUX4, 1'b0, 8'h50, 4'h9, 4'h9},
      '{LMD_MUX4, 1'b1, 8'h50, 4'h6, 4'h6}};
   logic clk_i = 1'b0, rst_n_i = 1'b0, cfg_load_i = 1'b0, clr = 1'b0;
   logic cfg_half_bias_i = 1'b0, cfg_enable_i = 1'b0, wr_en_i = 1'b0;
   logic half = 1'b0;
   lmd_mode_t    cfg_mode_i = LMD_MUX4;
   logic [7:0]   wr_col_i = 8'h00, col = 8'h00, bp_top, bp_bot;
   logic [3:0]   wr_data_i = 4'h0, on;
   logic [319:0] seg;
   int           dc, errors = 0, n_checks = 0, cyc = 0;
   always #25 clk_i = ~clk_i;
   lmd_top #(.FCLK_DIV(DIV)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .cfg_load_i(cfg_load_i), .cfg_mode_i(cfg_mode_i),
      .cfg_half_bias_i(cfg_half_bias_i), .cfg_enable_i(cfg_enable_i),
      .wr_en_i(wr_en_i), .wr_col_i(wr_col_i), .wr_data_i(wr_data_i),
      .backplane_top_o(bp_top), .backplane_bottom_o(bp_bot),
      .segment_outputs_o(seg));
   lmd_panel_model u_panel (.clk_i(clk_i), .clr_i(clr), .half_i(half),
      .bp_i(bp_top), .seg_i(seg[2*col+:2]), .on_o(on), .dc_o(dc));
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         errors++;
         conclude();
      end
   end
   task automatic cfg(input lmd_mode_t m, input logic h, input logic en);
      @(posedge clk_i);
      cfg_load_i      <= 1'b1;
      cfg_mode_i      <= m;
      cfg_half_bias_i <= h;
      cfg_enable_i <= en;
      half <= h;
      @(posedge clk_i);
      cfg_load_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] c, input logic [3:0] d);
      @(posedge clk_i);
      {wr_en_i, wr_col_i, wr_data_i} <= {1'b1, c, d};
      @(posedge clk_i);
      wr_en_i <= 1'b0;
   endtask
   // settle past the next frame start, then watch two whole frames
   task automatic look(input logic [7:0] c, input logic [3:0] e);
      col <= c;
      repeat (3 * FR) @(posedge clk_i);
      clr <= 1'b1;
      @(posedge clk_i);
      clr <= 1'b0;
      repeat (2 * FR) @(posedge clk_i);
      #1;
      `CHK(on, e)
      `CHK(dc, 0)
   endtask
   task automatic supply();
      #1;
      `CHK(bp_bot, 8'hFF)
      `CHK(seg, {320{1'b1}})
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      supply();
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         cfg(ROWS[i].m, ROWS[i].h, 1'b1);
         wr(ROWS[i].c, ROWS[i].d);
         look(ROWS[i].c, ROWS[i].e);
         $display("test row %0d done", i);
      end
      cfg(LMD_STATIC, 1'b0, 1'b1);
      cfg(LMD_MUX4, 1'b0, 1'b1);
      wr(8'h9F, 4'h5);
      wr(8'hA0, 4'hA);
      look(8'h9F, 4'h5);
      $display("test last load done");
      cfg(LMD_MUX4, 1'b0, 1'b0);
      repeat (3) @(posedge clk_i);
      supply();
      $display("test disable done");
      cfg(LMD_STATIC, 1'b0, 1'b1);
      repeat (3) @(posedge clk_i);
      rst_n_i <= 1'b0;
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      supply();
      $display("test second reset done");
      conclude();
   end
endmodule // lmd_top_bench
`default_nettype wire
